//--- hdl/ccpw_pkg.sv
package ccpw_pkg;
   localparam logic [7:0] ADDR_TMR_PERIOD = 8'h00;
   localparam logic [7:0] ADDR_TMR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_DUTY = 8'h08;
   localparam logic [7:0] ADDR_MOD_CTRL = 8'h0c;
   localparam logic [7:0] ADDR_COUNT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
   localparam logic [7:0] ADDR_SLEEP = 8'h1c;
   localparam int TMR_ON_BIT = 0;
   localparam int TMR_KEEP_BIT = 1;
   localparam int MODE_LSB = 0;
   localparam int MODE_W = 2;
   localparam int MOD_EN_BIT = 2;
   localparam int IRQ_PERIOD_BIT = 0;
   localparam int IRQ_CMP_BIT = 1;
   localparam int IRQ_W = 2;
   localparam int DUTY_W = 16;
   localparam int RES_W = 10;
   localparam int PRESC_DIV = 4;
   localparam logic [1:0] PRESC_LAST = 2'h3;
   localparam logic [7:0] PERIOD_RST = 8'hff;
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_COMPARE = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;

   typedef struct packed {
      logic [7:0] addr;
      logic write;
      logic [31:0] wdata;
   } ccpw_req_t;
endpackage

//--- hdl/ccpw_top.sv
`timescale 1ns/1ns
module ccpw_top (
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [31:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic SLEEP_I,
   output logic PWM_OUTPUT_PIN_O,
   output logic IRQ_O,
   output logic WAKE_O
);
   ////////////////////////////////////////////////////////////////////////////////
   ccpw_pkg::ccpw_req_t req;
   logic [7:0] period_ff;
   logic [1:0] tmr_ctrl_ff;
   logic [15:0] duty_ff;
   logic [15:0] duty_act_ff;
   logic [2:0] mod_ctrl_ff;
   logic [ccpw_pkg::IRQ_W-1:0] stat_ff;
   logic [ccpw_pkg::IRQ_W-1:0] mask_ff;
   logic [1:0] presc_ff;
   logic [7:0] tmr_ff;
   logic [9:0] cnt10_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic slverr_ff;
   logic pin_ff;
   logic irq_ff;
   logic wake_ff;

   assign req = '{addr: PADDR_I[7:0], write: PWRITE_I, wdata: PWDATA_I};

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
      addr_hit = (a == reg_addr);
   endfunction

   function automatic logic [31:0] rfield(input logic [15:0] v);
      rfield = {16'h0000, v};
   endfunction

   wire setup = PSEL_I && !PENABLE_I;
   wire first_acc = PSEL_I && PENABLE_I && !pready_ff;
   wire acc = PSEL_I && PENABLE_I && pready_ff;
   wire page_ok = (PADDR_I[31:8] == 24'h000000);
   wire align_ok = (PADDR_I[1:0] == 2'h0);
   wire in_map = page_ok && align_ok && (req.addr <= ccpw_pkg::ADDR_SLEEP);
   // writes outside the map are dropped
   wire wr = acc && req.write && in_map;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode
   wire wr_period = wr && addr_hit(req.addr, ccpw_pkg::ADDR_TMR_PERIOD);
   wire wr_tctrl = wr && addr_hit(req.addr, ccpw_pkg::ADDR_TMR_CTRL);
   wire wr_duty = wr && addr_hit(req.addr, ccpw_pkg::ADDR_DUTY);
   wire wr_mctrl = wr && addr_hit(req.addr, ccpw_pkg::ADDR_MOD_CTRL);
   wire wr_stat = wr && addr_hit(req.addr, ccpw_pkg::ADDR_IRQ_STAT);
   wire wr_mask = wr && addr_hit(req.addr, ccpw_pkg::ADDR_IRQ_MASK);
   wire [1:0] stat_clr = wr_stat ? PWDATA_I[ccpw_pkg::IRQ_W-1:0] : 2'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // register next values
   wire [7:0] nxt_period = wr_period ? PWDATA_I[7:0] : period_ff;
   wire [1:0] nxt_tmr_ctrl = wr_tctrl ? PWDATA_I[1:0] : tmr_ctrl_ff;
   wire [15:0] nxt_duty = wr_duty ? PWDATA_I[ccpw_pkg::DUTY_W-1:0] : duty_ff;
   wire [2:0] nxt_mod_ctrl = wr_mctrl ? PWDATA_I[2:0] : mod_ctrl_ff;
   wire [1:0] nxt_mask = wr_mask ? PWDATA_I[ccpw_pkg::IRQ_W-1:0] : mask_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // time base
   wire [1:0] mode = mod_ctrl_ff[ccpw_pkg::MODE_LSB +: ccpw_pkg::MODE_W];
   wire mod_en = mod_ctrl_ff[ccpw_pkg::MOD_EN_BIT];
   wire pwm_sel = mod_en && (mode == ccpw_pkg::MODE_PWM);
   wire cmp_sel = mod_en && (mode == ccpw_pkg::MODE_COMPARE);
   wire tmr_on = tmr_ctrl_ff[ccpw_pkg::TMR_ON_BIT];
   wire tmr_keep = tmr_ctrl_ff[ccpw_pkg::TMR_KEEP_BIT];
   // time base stalls in sleep unless it runs on a clock kept alive
   wire tb_live = tmr_on && (!SLEEP_I || tmr_keep);
   // one timer step every fourth system clock
   wire tick = tb_live && (presc_ff == ccpw_pkg::PRESC_LAST);
   wire [1:0] nxt_presc = tb_live ? presc_ff + 2'h1 : presc_ff;
   // timer restarts on period match, giving the period boundary
   wire per_match = tick && (tmr_ff == period_ff);
   wire [7:0] tmr_inc = tmr_ff + 8'h01;
   wire [7:0] nxt_tmr = per_match ? 8'h00 : (tick ? tmr_inc : tmr_ff);
   // 10-bit count: timer in the upper 8 bits, prescaler in the lower 2
   wire [9:0] nxt_cnt10 = {nxt_tmr, nxt_presc};
   // duty value latched at the period boundary and on every clock while the timer is off
   wire [15:0] nxt_duty_act = (per_match || !tmr_on) ? duty_ff : duty_act_ff;
   // only the low ten bits set the steps, more steps give a longer high
   wire [9:0] duty10 = duty_act_ff[ccpw_pkg::RES_W-1:0];
   wire [9:0] nxt_duty10 = nxt_duty_act[ccpw_pkg::RES_W-1:0];

   ////////////////////////////////////////////////////////////////////////////////
   // waveform
   // high from period start until count reaches duty; zero stays low
   // a duty beyond the period never matches so the output stays high
   // the new duty already shapes the first step of its period
   wire pin_on = nxt_cnt10 < nxt_duty10;
   wire nxt_pin = pwm_sel && pin_on;
   // compare match on the last prescaler step of the matching timer value
   wire cmp_evt = cmp_sel && tick && ({tmr_ff, ccpw_pkg::PRESC_LAST} == duty10);
   wire per_evt = per_match && mod_en;
   wire [ccpw_pkg::IRQ_W-1:0] evt = {cmp_evt, per_evt};

   ////////////////////////////////////////////////////////////////////////////////
   // interrupts: set wins over write-one-to-clear
   wire [ccpw_pkg::IRQ_W-1:0] nxt_stat = (stat_ff & ~stat_clr) | evt;
   wire [ccpw_pkg::IRQ_W-1:0] pend = nxt_stat & nxt_mask;
   wire nxt_irq = |pend;
   // wake only from an enabled compare event
   wire nxt_wake = SLEEP_I && pend[ccpw_pkg::IRQ_CMP_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // read mux
   wire [31:0] rd_period = rfield({8'h00, period_ff});
   wire [31:0] rd_tctrl = rfield({14'h0000, tmr_ctrl_ff});
   wire [31:0] rd_duty = rfield(duty_ff);
   wire [31:0] rd_mctrl = rfield({13'h0000, mod_ctrl_ff});
   wire [31:0] rd_count = rfield({6'h00, cnt10_ff});
   wire [31:0] rd_stat = rfield({14'h0000, stat_ff});
   wire [31:0] rd_mask = rfield({14'h0000, mask_ff});
   wire [31:0] rd_sleep = rfield({15'h0000, SLEEP_I});
   logic [31:0] rd;
   always_comb begin
      rd = 32'h00000000;
      unique case (req.addr)
         ccpw_pkg::ADDR_TMR_PERIOD: rd = rd_period;
         ccpw_pkg::ADDR_TMR_CTRL: rd = rd_tctrl;
         ccpw_pkg::ADDR_DUTY: rd = rd_duty;
         ccpw_pkg::ADDR_MOD_CTRL: rd = rd_mctrl;
         ccpw_pkg::ADDR_COUNT: rd = rd_count;
         ccpw_pkg::ADDR_IRQ_STAT: rd = rd_stat;
         ccpw_pkg::ADDR_IRQ_MASK: rd = rd_mask;
         ccpw_pkg::ADDR_SLEEP: rd = rd_sleep;
         default: rd = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus answer: one wait state, ready pulses in the second access cycle
   wire nxt_slverr = first_acc && !in_map;
   wire [31:0] nxt_prdata = (in_map && !req.write) ? rd : 32'h00000000;

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         pready_ff <= 1'b0;
      end else begin
         pready_ff <= first_acc;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         slverr_ff <= 1'b0;
      end else begin
         slverr_ff <= nxt_slverr;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         prdata_ff <= 32'h00000000;
      end else if (first_acc) begin
         prdata_ff <= nxt_prdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // registers; same form each, period resets to PERIOD_RST, the others to zero
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         period_ff <= ccpw_pkg::PERIOD_RST;
      end else begin
         period_ff <= nxt_period;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         tmr_ctrl_ff <= 2'h0;
      end else begin
         tmr_ctrl_ff <= nxt_tmr_ctrl;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         duty_ff <= 16'h0000;
      end else begin
         duty_ff <= nxt_duty;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         mod_ctrl_ff <= 3'h0;
      end else begin
         mod_ctrl_ff <= nxt_mod_ctrl;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         mask_ff <= 2'h0;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // timer state
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         presc_ff <= 2'h0;
      end else begin
         presc_ff <= nxt_presc;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         tmr_ff <= 8'h00;
      end else begin
         tmr_ff <= nxt_tmr;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         cnt10_ff <= 10'h000;
      end else begin
         cnt10_ff <= nxt_cnt10;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         duty_act_ff <= 16'h0000;
      end else begin
         duty_act_ff <= nxt_duty_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status and outputs
   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         stat_ff <= 2'h0;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         pin_ff <= 1'b0;
      end else begin
         pin_ff <= nxt_pin;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         wake_ff <= 1'b0;
      end else begin
         wake_ff <= nxt_wake;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // ports
   assign PRDATA_O = prdata_ff;
   assign PREADY_O = pready_ff;
   assign PSLVERR_O = slverr_ff;
   assign PWM_OUTPUT_PIN_O = pin_ff;
   assign IRQ_O = irq_ff;
   assign WAKE_O = wake_ff;

   wire unused = setup;
endmodule

//--- test/ccpw_load.sv
`timescale 1ns/1ns
module ccpw_load (
   input wire logic clk_i,
   input wire logic pin_i,
   input wire logic clr_i,
   output int hi_o
);
   // load takes power while the pin is high
   always @(posedge clk_i) begin
      if (clr_i) hi_o <= 0;
      else if (pin_i === 1'b1) hi_o <= hi_o + 1;
   end
endmodule

//--- test/ccpw_top_chk.sv
`timescale 1ns/1ns
module ccpw_top_chk (
   input wire logic CLK_SYS_I,
   input wire logic SRST_I,
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic SLEEP_I,
   input wire logic IRQ_O,
   input wire logic WAKE_O
);
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);
   sequence s_acc; PSEL_I && !PENABLE_I ##1 PSEL_I && PENABLE_I; endsequence
   sequence s_idle; !PSEL_I && !$past(PSEL_I); endsequence
   property p_rdy; s_acc |=> PREADY_O; endproperty
   property p_one; PREADY_O |=> !PREADY_O; endproperty
   property p_src; PREADY_O |-> $past(PSEL_I && PENABLE_I); endproperty
   property p_hold; PREADY_O |-> PSEL_I && PENABLE_I; endproperty
   property p_err; PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0; endproperty
   property p_wake; WAKE_O |-> $past(SLEEP_I) && IRQ_O; endproperty
   property p_irq; (IRQ_O and s_idle) |=> IRQ_O; endproperty
   property p_wkeep; ((WAKE_O && SLEEP_I) and s_idle) |=> WAKE_O; endproperty
   a_rdy: assert property (p_rdy) else $error("ready late");
   a_one: assert property (p_one) else $error("ready too long");
   a_src: assert property (p_src) else $error("ready unasked");
   a_hold: assert property (p_hold) else $error("ready outside access");
   a_err: assert property (p_err) else $error("bad error response");
   a_wake: assert property (p_wake) else $error("wake without cause");
   a_irq: assert property (p_irq) else $error("interrupt dropped");
   a_wkeep: assert property (p_wkeep) else $error("wake dropped");
endmodule
bind ccpw_top ccpw_top_chk u_chk (.CLK_SYS_I, .SRST_I, .PSEL_I, .PENABLE_I, .PRDATA_O,
   .PREADY_O, .PSLVERR_O, .SLEEP_I, .IRQ_O, .WAKE_O);

//--- test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, sleep = 1'b0;
   logic clr = 1'b0, rdy, err, pin, irq, wake;
   logic [31:0] padr = 32'h0, pwd = 32'h0, prd;
   logic [33:0] q[$];
   logic [33:0] nt;
   int hi, bad_count, n_tests, seed, p, dl;
   ccpw_top DUT (.CLK_SYS_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
      .PSLVERR_O(err), .SLEEP_I(sleep), .PWM_OUTPUT_PIN_O(pin), .IRQ_O(irq), .WAKE_O(wake));
   ccpw_load LOAD (.clk_i(clk), .pin_i(pin), .clr_i(clr), .hi_o(hi));
   initial begin
      forever #10 clk = ~clk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // note {check data, error, data}, compared when ready appears
   task apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [33:0] n);
      q.push_back(n);
      psel <= 1'b1;
      padr <= {24'h0, a};
      pwr <= w;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e); apb(a, 1'b0, 32'h0, {2'b10, e}); endtask
   task wr(input logic [7:0] a, input logic [31:0] d); apb(a, 1'b1, d, 34'h0); endtask
   always @(posedge clk) begin
      if (rdy === 1'b1) begin
         nt = q.pop_front();
         chk("pslverr", {31'h0, nt[32]}, {31'h0, err});
         if (nt[33]) chk("prdata", nt[31:0], prd);
      end
   end
   // four periods of high time through the load
   task pwm(input int per, input logic [15:0] d);
      wr(ccpw_pkg::ADDR_TMR_PERIOD, per);
      wr(ccpw_pkg::ADDR_DUTY, {16'h0, d});
      repeat (1100 + 8 * (per + 1)) @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (16 * (per + 1) + 1) @(posedge clk);
      chk("high time", 4 * d[9:0], 32'(hi));
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      report_and_stop();
   end
   initial begin
      seed = 63631;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      rd(ccpw_pkg::ADDR_TMR_PERIOD, 32'hff);
      rd(ccpw_pkg::ADDR_DUTY, 32'h0);
      apb(8'h20, 1'b1, 32'h5, {2'b01, 32'h0});
      apb(8'h20, 1'b0, 32'h0, {2'b11, 32'h0});
      wr(ccpw_pkg::ADDR_TMR_CTRL, 32'h1);
      wr(ccpw_pkg::ADDR_MOD_CTRL, 32'h6);
      for (int i = 0; i < 6; i++) begin
         p = $random(seed) & 7;
         dl = (i == 0) ? 0 : (i == 1) ? 4 * (p + 1) : ($random(seed) & 63) % (4 * p + 5);
         pwm(p, (16'($random(seed)) & 16'hfc00) | 16'(dl));
      end
      chk("irq masked", 32'h0, {31'h0, irq});
      wr(ccpw_pkg::ADDR_IRQ_MASK, 32'h1);
      chk("irq raised", 32'h1, {31'h0, irq});
      wr(ccpw_pkg::ADDR_TMR_CTRL, 32'h0);
      wr(ccpw_pkg::ADDR_IRQ_STAT, 32'h3);
      chk("irq cleared", 32'h0, {31'h0, irq});
      rd(ccpw_pkg::ADDR_IRQ_STAT, 32'h0);
      wr(ccpw_pkg::ADDR_MOD_CTRL, 32'h5);
      wr(ccpw_pkg::ADDR_DUTY, 32'h3);
      wr(ccpw_pkg::ADDR_TMR_CTRL, 32'h3);
      sleep <= 1'b1;
      repeat (80) @(posedge clk);
      chk("wake masked", 32'h0, {31'h0, wake});
      wr(ccpw_pkg::ADDR_IRQ_MASK, 32'h2);
      chk("wake", 32'h1, {31'h0, wake});
      wr(ccpw_pkg::ADDR_TMR_CTRL, 32'h1);
      wr(ccpw_pkg::ADDR_IRQ_STAT, 32'h3);
      repeat (80) @(posedge clk);
      chk("sleep stall", 32'h0, {31'h0, wake});
      report_and_stop();
   end
endmodule
